//--- hdl/power_mode_clock_selector.sv
// Power-managed mode controller and glitch-free system clock source selector
`timescale 1ns/100ps
`default_nettype none
`include "pmcs_map.svh"

module power_mode_clock_selector
    import pmcs_pkg::*;
#(
    parameter int PLL_LOCK_CYCLES     = (`PLL_LOCK_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
    parameter int HF_STABILISE_CYCLES = 8,
    parameter bit REGULATED           = 1'b1
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        srst,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // Core events
    input  wire logic        sleep_exec,
    input  wire logic        wake_event,
    // Configuration and neighbour enables
    input  wire logic        pll_enable,
    input  wire logic        two_speed_enable,
    input  wire logic        clock_monitor_enable,
    input  wire logic        watchdog_enable,
    input  wire logic        secondary_osc_enable,
    // Oscillator ready levels, asynchronous
    input  wire logic [3:0]  osc_ready,
    // Clock gating and source control
    output logic             cpu_clk_en,
    output logic             periph_clk_en,
    output logic [1:0]       clk_source,
    output logic             primary_osc_on,
    output logic             secondary_osc_on,
    output logic             hf_osc_on,
    output logic             lf_osc_on,
    output logic [2:0]       internal_freq_select,
    output logic [1:0]       regulator_sleep_power_field
);

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Declarations

    localparam logic [18:0] PRI_WAIT_BASE = `OST_PERIODS;
    localparam logic [18:0] PRI_WAIT_PLL  = 19'(PLL_LOCK_CYCLES);
    localparam logic [7:0]  HF_LAST       = 8'(HF_STABILISE_CYCLES);

    ctrl_state_t q;
    ctrl_state_t n;

    logic        pri_rdy;
    logic        sec_rdy;
    logic        hf_rdy;
    logic        lf_rdy;
    src_t        tgt;
    logic        sec_allowed;
    logic        hf_want;
    logic        fast_start;
    logic [18:0] pri_limit;
    logic        pri_ready_full;
    logic        tgt_ready;
    logic        apb_first;
    logic        wr_fire;
    logic        hit;
    logic [31:0] rd_val;
    logic        sleep_n;

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Derived conditions

    assign pri_rdy        = q.rdy[`RDY_PRI];
    assign sec_rdy        = q.rdy[`RDY_SEC];
    assign hf_rdy         = q.rdy[`RDY_HF];
    assign lf_rdy         = q.rdy[`RDY_LF];
    assign tgt            = src_of(q.csel);  // R2 R3
    assign sec_allowed    = q.sec_go | secondary_osc_enable;
    assign hf_want        = (q.freq != 3'h0) | q.int_src;  // R11 R14
    assign fast_start     = two_speed_enable | clock_monitor_enable;
    assign pri_limit      = pll_enable ? PRI_WAIT_BASE + PRI_WAIT_PLL : PRI_WAIT_BASE;  // R19
    assign pri_ready_full = q.pri_on & pri_rdy & (q.pri_cnt == pri_limit);
    assign apb_first      = psel & penable & ~q.pready;
    assign wr_fire        = psel & penable & q.pready & pwrite;

    // Whether the chosen source can take over now
    always_comb begin
        unique case (tgt)
            SRC_PRI: tgt_ready = pri_ready_full;          // R8 R15
            SRC_SEC: tgt_ready = sec_allowed & sec_rdy;   // R7
            SRC_INT: tgt_ready = hf_want | lf_rdy;        // R12
            default: tgt_ready = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Register read decode

    always_comb begin
        hit    = 1'b1;
        rd_val = 32'h0000_0000;
        case (paddr)
            `OSC_CTRL_OFS: begin
                rd_val[`IDLE_BIT]              = q.idle_en;
                rd_val[`FREQ_MSB:`FREQ_LSB]    = q.freq;
                rd_val[`OST_BIT]               = q.ost;
                rd_val[`HFS_BIT]               = q.hf_stable;
                rd_val[`CSEL_MSB:`CSEL_LSB]    = q.csel;
            end
            `OSC_CTRL2_OFS: begin
                rd_val[`SECRUN_BIT]            = q.secondary_run_mode;
                rd_val[`INTERNAL_SOURCE_SELECT_BIT]            = q.int_src;
                rd_val[`SECGO_BIT]             = q.sec_go;
                rd_val[`LFS_BIT]               = q.lf_stable;
            end
            `REG_CTRL_OFS: begin
                if (REGULATED) begin
                    rd_val[`VREG_MSB:`VREG_LSB] = q.vreg;  // R20
                end else begin
                    hit = 1'b0;
                end
            end
            `MODE_STAT_OFS: begin
                rd_val[5:0]                    = q.st;
                rd_val[`STAT_SRC_LSB +: 2]     = q.cur;
            end
            default: begin
                hit = 1'b0;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        n = q;

        // Ready levels: three stages, a change counts once the last two agree
        n.sync1 = osc_ready;
        n.sync2 = q.sync1;
        n.sync3 = q.sync2;
        if (q.sync2 == q.sync3) begin
            n.rdy = q.sync3;
        end

        // APB: one wait cycle, answer in the second access cycle
        n.pready = apb_first;
        if (apb_first) begin
            n.prdata  = rd_val;
            n.pslverr = ~hit;
        end
        if (wr_fire) begin
            case (paddr)
                `OSC_CTRL_OFS: begin
                    n.idle_en = pwdata[`IDLE_BIT];
                    n.freq    = pwdata[`FREQ_MSB:`FREQ_LSB];  // R10
                    n.csel    = pwdata[`CSEL_MSB:`CSEL_LSB];  // R1
                end
                `OSC_CTRL2_OFS: begin
                    n.int_src = pwdata[`INTERNAL_SOURCE_SELECT_BIT];
                    n.sec_go  = pwdata[`SECGO_BIT];
                end
                `REG_CTRL_OFS: begin
                    if (REGULATED) begin
                        n.vreg = pwdata[`VREG_MSB:`VREG_LSB];  // R20 R21
                    end
                end
                default: begin
                end
            endcase
        end

        // Primary start-up timer, plus PLL lock when used
        if (!q.pri_on || !pri_rdy) begin
            n.pri_cnt = 19'h0_0000;
        end else if (q.pri_cnt != pri_limit) begin
            n.pri_cnt = q.pri_cnt + 19'h0_0001;  // R19
        end

        // High-frequency stabilisation; clocks keep running meanwhile
        if (!q.hf_on || !hf_rdy) begin
            n.hf_cnt = 8'h00;
        end else if (q.hf_cnt != HF_LAST) begin
            n.hf_cnt = q.hf_cnt + 8'h01;
        end
        n.hf_stable = q.hf_on & hf_rdy & (q.hf_cnt == HF_LAST);  // R12 R13 R23

        // Mode sequencer
        unique case (q.st)
            ST_RUN, ST_WAIT: begin
                if (sleep_exec) begin
                    n.st = q.idle_en ? ST_IDLE : ST_SLEEP;  // R4 R17
                end else if (tgt == q.cur) begin
                    n.st = ST_RUN;
                end else if (tgt_ready) begin
                    n.st   = ST_GAP;  // R1
                    n.pend = tgt;
                    n.gap  = 2'h0;
                end else begin
                    n.st = ST_WAIT;  // R7 R8 R15
                end
            end
            ST_GAP: begin
                n.gap = q.gap + 2'h1;
                if (q.gap == `SWITCH_GAP_LAST) begin
                    n.cur = q.pend;  // R22 R19
                    n.st  = ST_RUN;
                end
            end
            ST_IDLE: begin
                if (wake_event) begin
                    n.st = ST_RUN;
                end
            end
            ST_SLEEP: begin
                if (wake_event) begin
                    n.st = ST_WAKE;
                end
            end
            ST_WAKE: begin
                if (fast_start) begin
                    n.cur = SRC_INT;  // R5 R18
                    n.st  = ST_RUN;
                end else if (tgt_ready) begin
                    n.cur = tgt;  // R5 R18
                    n.st  = ST_RUN;
                end
            end
            default: begin
                n.st = ST_WAKE;
            end
        endcase

        // Status flags once a new source drives the device
        if (n.st == ST_RUN && (q.st == ST_GAP || q.st == ST_WAKE)) begin
            n.ost     = (n.cur == SRC_PRI);  // R6 R8 R9 R15 R18 R23
            n.secondary_run_mode = (n.cur == SRC_SEC);  // R6 R8
        end
        if (q.st == ST_GAP && n.cur == SRC_PRI && q.cur == SRC_INT) begin
            n.hf_cnt    = 8'h00;  // R15
            n.hf_stable = 1'b0;
        end

        // Oscillator enables follow the next mode
        sleep_n     = (n.st == ST_SLEEP);
        n.pri_on    = ~sleep_n & ((n.cur == SRC_PRI) | (tgt == SRC_PRI));  // R6 R9 R16
        n.sec_on    = sleep_n ? secondary_osc_enable : (sec_allowed | (n.cur == SRC_SEC));  // R8 R16
        n.hf_on     = ~sleep_n & hf_want;  // R11 R12
        n.lf_on     = watchdog_enable | (~sleep_n & (clock_monitor_enable | ~hf_want));  // R15 R16
        n.lf_stable = ~sleep_n & q.lf_on & lf_rdy;  // R14
        if (sleep_n) begin
            n.ost       = 1'b0;  // R16
            n.secondary_run_mode   = 1'b0;
            n.hf_stable = 1'b0;
        end

        // Clock gates stay closed through the switch gap and for the cycle of every source change
        n.cpu_en = ((n.st == ST_RUN) | (n.st == ST_WAIT)) & (n.cur == q.cur);  // R4 R22
        n.per_en = ((n.st == ST_RUN) | (n.st == ST_WAIT) | (n.st == ST_IDLE))
                   & (n.cur == q.cur);  // R4 R22
    end

    ////////////////////////////////////////////////////////////////////////////////////////////
    // State register

    always_ff @(posedge clk) begin
        if (srst) begin
            q     <= '0;
            q.st  <= ST_WAKE;  // R5
            q.cur <= SRC_PRI;
        end else begin
            q <= n;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Outputs

    assign prdata                      = q.prdata;
    assign pready                      = q.pready;
    assign pslverr                     = q.pslverr;
    assign cpu_clk_en                  = q.cpu_en;
    assign periph_clk_en               = q.per_en;
    assign clk_source                  = q.cur;
    assign primary_osc_on              = q.pri_on;
    assign secondary_osc_on            = q.sec_on;
    assign hf_osc_on                   = q.hf_on;
    assign lf_osc_on                   = q.lf_on;
    assign internal_freq_select        = q.freq;
    assign regulator_sleep_power_field = q.vreg;

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Assertions

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);

    sequence sleep_cmd_s(logic idle);
        q.st == ST_RUN && sleep_exec && q.idle_en == idle;
    endsequence

    sequence lf_only_s;
        (q.freq == 3'h0 && !q.int_src)[*2];
    endsequence

    a_sleep_stops_all: assert property (sleep_cmd_s(1'b0) |=> !cpu_clk_en  // R4
                                        && !periph_clk_en && q.st == ST_SLEEP)
        else $error("Sleep did not stop both clocks");

    a_idle_keeps_periph: assert property (sleep_cmd_s(1'b1) |=> !cpu_clk_en  // R4
                                          && periph_clk_en && q.st == ST_IDLE)
        else $error("Idle did not gate only the cpu clock");

    a_run_follows_select: assert property ((q.st == ST_RUN && $past(q.st) == ST_RUN  // R2
                                           && $stable(q.csel)) |-> clk_source == src_of(q.csel))
        else $error("Running source differs from select field");

    a_secondary_run_mode_flags: assert property ((q.st == ST_RUN && clk_source == SRC_SEC  // R6
        && tgt == SRC_SEC) |-> q.secondary_run_mode && !q.ost && !primary_osc_on)
        else $error("Secondary run flags or primary enable wrong");

    a_int_stops_primary: assert property ((q.st == ST_RUN && clk_source == SRC_INT  // R9
                                          && tgt == SRC_INT) |-> !primary_osc_on && !q.ost)
        else $error("Internal run left primary on or timer flag set");

    a_switch_gated: assert property ($changed(clk_source) |-> !periph_clk_en  // R22
                                     && !cpu_clk_en && $past(!periph_clk_en))
        else $error("Clock source changed while clocks were enabled");

    a_hf_off_flag: assert property (lf_only_s |-> !hf_osc_on ##1 !q.hf_stable)  // R11
        else $error("High-frequency output on with zero frequency field");

    a_sleep_clears: assert property (q.st == ST_SLEEP |-> !q.ost && !q.hf_stable  // R16
                                     && !q.secondary_run_mode && !primary_osc_on && !cpu_clk_en)
        else $error("Sleep left a status flag or primary oscillator on");

    a_sec_waits_go: assert property ((q.st == ST_WAIT && tgt == SRC_SEC && !sec_allowed)  // R7
                                     |=> clk_source != SRC_SEC)
        else $error("Secondary run entered without go or enable");

    a_gap_gated: assert property (q.st == ST_GAP |-> !cpu_clk_en && !periph_clk_en)  // R22
        else $error("Clock on in switch gap");

    a_wake_fast: assert property (q.st == ST_WAKE && fast_start |=> clk_source == SRC_INT)  // R18
        else $error("Fast wake not internal");

    a_idle_wake: assert property (q.st == ST_IDLE && wake_event  // R4
        |=> cpu_clk_en && periph_clk_en)
        else $error("Idle wake left a clock off");

    a_exit_flags: assert property (q.st == ST_GAP && q.gap == `SWITCH_GAP_LAST  // R8 R15
        && q.pend == SRC_PRI |=> q.ost && !q.secondary_run_mode)
        else $error("Primary switch flags wrong");

endmodule
`default_nettype wire

//--- hdl/pmcs_map.svh
// Register offsets, field positions and timing figures of the clock selector
// Functional notes
// R1 - Select change switches at once if source runs
// R2 - Select 01 secondary crystal, 00 primary
// R3 - Upper select bit set chooses internal block
// R4 - Sleep samples idle bit: idle or full sleep
// R5 - Reset starts primary run, unless two-speed start; the code also starts on internal when clock monitor is enabled
// R6 - Secondary run: primary off, flags set/cleared
// R7 - Secondary entry waits for go and ready
// R8 - Secondary to primary waits primary ready
// R9 - Internal run stops primary, clears timer flag
// R10 - Internal frequency field writable, acts immediately
// R11 - Zero frequency, no source select: high-frequency off
// R12 - High-frequency stable flag set after stabilising
// R13 - Stable flag kept when already stable
// R14 - Stability flag follows low/high source encoding
// R15 - Internal to primary waits, clears stable flag
// R16 - Sleep stops oscillator, clears status flags
// R17 - Sleep entry needs no clock switch
// R18 - Wake waits for source or runs internal
// R19 - Start-up 1024 periods, PLL 2 ms, switch 2-4
// R20 - Regulator register only on regulated variant
// R21 - Regulator sleep field encodes four power levels
// R22 - Source switches are glitch-free, clocks gated
// R23 - Status bits read-only, updated in clock domain
`ifndef PMCS_MAP_SVH
`define PMCS_MAP_SVH

// Register byte offsets
`define OSC_CTRL_OFS     8'h00
`define OSC_CTRL2_OFS    8'h04
`define REG_CTRL_OFS     8'h08
`define MODE_STAT_OFS    8'h0C

// Oscillator control fields
`define IDLE_BIT         7
`define FREQ_MSB         6
`define FREQ_LSB         4
`define OST_BIT          3
`define HFS_BIT          2
`define CSEL_MSB         1
`define CSEL_LSB         0

// Second oscillator control fields
`define SECRUN_BIT       6
`define INTERNAL_SOURCE_SELECT_BIT       5
`define SECGO_BIT        3
`define LFS_BIT          0

// Regulator field and mode status fields
`define VREG_MSB         1
`define VREG_LSB         0
`define STAT_SRC_LSB     8

// Oscillator ready input positions
`define RDY_PRI          0
`define RDY_SEC          1
`define RDY_HF           2
`define RDY_LF           3

// Timing
`define OST_PERIODS      19'h0_0400
`define PLL_LOCK_US      2000
`define CLK_PERIOD_NS    10
`define SWITCH_GAP_LAST  2'h1

`endif

//--- hdl/pmcs_pkg.sv
// Types shared by the clock selector
package pmcs_pkg;

    typedef enum logic [5:0] {
        ST_RUN   = 6'h01,
        ST_WAIT  = 6'h02,
        ST_GAP   = 6'h04,
        ST_IDLE  = 6'h08,
        ST_SLEEP = 6'h10,
        ST_WAKE  = 6'h20
    } state_t;

    typedef enum logic [1:0] {
        SRC_PRI = 2'h0,
        SRC_SEC = 2'h1,
        SRC_INT = 2'h2
    } src_t;

    typedef struct packed {
        state_t      st;
        src_t        cur;
        src_t        pend;
        logic [1:0]  gap;
        logic [18:0] pri_cnt;
        logic [7:0]  hf_cnt;
        logic        idle_en;
        logic [2:0]  freq;
        logic [1:0]  csel;
        logic        int_src;
        logic        sec_go;
        logic [1:0]  vreg;
        logic        ost;
        logic        hf_stable;
        logic        lf_stable;
        logic        secondary_run_mode;
        logic [3:0]  sync1;
        logic [3:0]  sync2;
        logic [3:0]  sync3;
        logic [3:0]  rdy;
        logic        cpu_en;
        logic        per_en;
        logic        pri_on;
        logic        sec_on;
        logic        hf_on;
        logic        lf_on;
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } ctrl_state_t;

    // Source chosen by the two-bit select field
    function automatic src_t src_of(input logic [1:0] sel);
        src_t s;
        s = SRC_PRI;
        if (sel[1]) begin
            s = SRC_INT;
        end else if (sel[0]) begin
            s = SRC_SEC;
        end
        return s;
    endfunction

endpackage

//--- sim/core_model.sv
// CPU core and oscillator model that faces the clock selector
`timescale 1ns/100ps
`default_nettype none

module core_model #(
    parameter int READY_DELAY = 6
) (
    // Clock
    input  wire logic        clk,
    // APB master
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [7:0]       paddr,
    output logic [31:0]      pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr,
    // Core events
    output logic             sleep_exec,
    output logic             wake_event,
    // Oscillator enables and ready levels
    input  wire logic        primary_osc_on,
    input  wire logic        secondary_osc_on,
    input  wire logic        hf_osc_on,
    input  wire logic        lf_osc_on,
    output logic [3:0]       osc_ready
);
    int unsigned ready_cnt [4];
    logic [3:0]  osc_on;

    assign osc_on = {lf_osc_on, hf_osc_on, secondary_osc_on, primary_osc_on};

    initial begin
        {psel, penable, pwrite, sleep_exec, wake_event} = 5'h00;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        osc_ready = 4'h0;
    end

    // Ready rises a fixed time after an enable and drops at once when stopped
    always @(posedge clk) begin
        for (int i = 0; i < 4; i++) begin
            if (osc_on[i] !== 1'b1) begin
                ready_cnt[i] <= 0;
                osc_ready[i] <= 1'b0;
            end else if (ready_cnt[i] == READY_DELAY) begin
                osc_ready[i] <= 1'b1;
            end else begin
                ready_cnt[i] <= ready_cnt[i] + 1;
            end
        end
    end

    // One APB transfer, held until pready is seen high at a rising edge
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        pwdata <= ~d;
    endtask

    // One-cycle pulse of sleep or wake
    task automatic pulse(input bit wake);
        @(posedge clk);
        if (wake) wake_event <= 1'b1;
        else sleep_exec <= 1'b1;
        @(posedge clk);
        wake_event <= 1'b0;
        sleep_exec <= 1'b0;
    endtask
endmodule
`default_nettype wire

//--- sim/power_mode_clock_selector_tb.sv
// Self-checking testbench of the power mode clock selector
`timescale 1ns/100ps
`default_nettype none
`include "pmcs_map.svh"

`define CHK(act, exp) begin check_count++; if ((act) !== (exp)) begin fails++; \
    $display("Error t=%0t got %h exp %h", $time, (act), (exp)); end end

module power_mode_clock_selector_tb;
    import pmcs_pkg::*;

    typedef struct {
        logic [31:0] data;
        logic [31:0] mask;
        logic        err;
    } note_t;

    logic        clk, srst, psel, penable, pwrite, pready, pslverr;
    logic        sleep_exec, wake_event, pll_enable, two_speed_enable, watchdog_enable;
    logic        secondary_osc_enable, cpu_clk_en, periph_clk_en, clock_monitor_enable;
    logic        primary_osc_on, secondary_osc_on, hf_osc_on, lf_osc_on;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rnd;
    logic [3:0]  osc_ready;
    logic [1:0]  clk_source, regulator_sleep_power_field;
    logic [2:0]  internal_freq_select, f;
    int          fails, check_count, n;
    int          seed = 32'h27828f65;
    note_t       notes [$];
    note_t       nt;

    power_mode_clock_selector #(.PLL_LOCK_CYCLES(20), .HF_STABILISE_CYCLES(8)) dut (
        .clk(clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sleep_exec(sleep_exec), .wake_event(wake_event),
        .pll_enable(pll_enable), .two_speed_enable(two_speed_enable),
        .clock_monitor_enable(clock_monitor_enable), .watchdog_enable(watchdog_enable),
        .secondary_osc_enable(secondary_osc_enable), .osc_ready(osc_ready),
        .cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en), .clk_source(clk_source),
        .primary_osc_on(primary_osc_on), .secondary_osc_on(secondary_osc_on),
        .hf_osc_on(hf_osc_on), .lf_osc_on(lf_osc_on),
        .internal_freq_select(internal_freq_select),
        .regulator_sleep_power_field(regulator_sleep_power_field)
    );

    core_model core (
        .clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .sleep_exec(sleep_exec), .wake_event(wake_event),
        .primary_osc_on(primary_osc_on), .secondary_osc_on(secondary_osc_on),
        .hf_osc_on(hf_osc_on), .lf_osc_on(lf_osc_on), .osc_ready(osc_ready)
    );

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Bus tasks and waits

    task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] m,
                      input logic e);
        notes.push_back('{d & m, m, e});
        core.xfer(1'b0, a, 32'h0000_0000);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        notes.push_back('{32'h0000_0000, 32'h0000_0000, 1'b0});
        core.xfer(1'b1, a, d);
    endtask

    task automatic wait_src(input logic [1:0] s, input int lim);
        n = 0;
        while (clk_source !== s && n < lim) begin
            @(posedge clk);
            n++;
        end
        #1 `CHK(clk_source, s)
    endtask

    task automatic wait_cpu(input int lim);
        n = 0;
        while (cpu_clk_en !== 1'b1 && n < lim) begin
            @(posedge clk);
            n++;
        end
        #1 `CHK(cpu_clk_en, 1'b1)
    endtask

    task automatic do_reset(input logic two_speed);
        @(posedge clk);
        srst <= 1'b1;
        two_speed_enable <= two_speed;
        repeat (16) @(posedge clk);
        srst <= 1'b0;
    endtask

    task report_and_stop;
        $display("Checks %0d, mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Every answer takes the oldest note
    always @(posedge clk) begin
        if (pready === 1'b1) begin
            nt = notes.pop_front();
            `CHK(prdata & nt.mask, nt.data)
            `CHK(pslverr, nt.err)
        end
    end

    initial begin
        #600000;
        fails++;
        report_and_stop();
    end

    ////////////////////////////////////////////////////////////////////////////
    // Scenarios

    initial begin
        srst = 1'b1;
        {pll_enable, clock_monitor_enable} = 2'b10;
        two_speed_enable = 1'b0;
        watchdog_enable = 1'b1;
        secondary_osc_enable = 1'b0;
        do_reset(1'b0);
        wait_cpu(2000);
        `CHK(n >= 1044, 1'b1)
        `CHK(clk_source, SRC_PRI)
        rd(`OSC_CTRL_OFS, 32'h0000_0008, 32'hFFFF_FFFB, 1'b0);
        rd(8'h10, 32'h0000_0000, 32'hFFFF_FFFF, 1'b1);
        $display("Test reset done");
        for (int i = 0; i < 4; i++) begin
            rnd = $random(seed);
            wr(`REG_CTRL_OFS, {rnd[31:2], i[1:0]});
            rd(`REG_CTRL_OFS, {30'h0, i[1:0]}, 32'hFFFF_FFFF, 1'b0);
            `CHK(regulator_sleep_power_field, i[1:0])
        end
        $display("Test regulator done");
        rnd = $random(seed);
        f = rnd[2:0];
        wr(`OSC_CTRL_OFS, {25'h0, f, 4'h0});
        #1 `CHK(internal_freq_select, f)
        rd(`OSC_CTRL_OFS, {25'h0, f, 4'h8}, 32'hFFFF_FFFB, 1'b0);
        wr(`OSC_CTRL_OFS, {25'h0, f, 4'h1});
        repeat (40) @(posedge clk);
        #1 `CHK(clk_source, SRC_PRI)
        wr(`OSC_CTRL2_OFS, 32'h0000_0008);
        wait_src(SRC_SEC, 200);
        repeat (4) @(posedge clk);
        #1 `CHK(primary_osc_on, 1'b0)
        rd(`OSC_CTRL2_OFS, 32'h0000_0048, 32'h0000_0048, 1'b0);
        rd(`OSC_CTRL_OFS, 32'h0000_0001, 32'h0000_000B, 1'b0);
        $display("Test secondary entry done");
        wr(`OSC_CTRL_OFS, {25'h0, f, 4'h0});
        repeat (5) @(posedge clk);
        #1 `CHK(clk_source, SRC_SEC)
        wait_src(SRC_PRI, 2000);
        rd(`OSC_CTRL2_OFS, 32'h0000_0008, 32'h0000_0048, 1'b0);
        rd(`OSC_CTRL_OFS, 32'h0000_0008, 32'h0000_000B, 1'b0);
        `CHK(secondary_osc_on, 1'b1)
        $display("Test secondary exit done");
        wr(`OSC_CTRL_OFS, 32'h0000_0003);
        wait_src(SRC_INT, 200);
        repeat (5) @(posedge clk);
        #1 `CHK({primary_osc_on, hf_osc_on}, 2'b00)
        rd(`OSC_CTRL_OFS, 32'h0000_0003, 32'h0000_000F, 1'b0);
        rd(`OSC_CTRL2_OFS, 32'h0000_0001, 32'h0000_0001, 1'b0);
        wr(`OSC_CTRL_OFS, 32'h0000_0053);
        #1 `CHK(internal_freq_select, 3'h5)
        repeat (40) @(posedge clk);
        #1 `CHK(hf_osc_on, 1'b1)
        `CHK(cpu_clk_en, 1'b1)
        rd(`OSC_CTRL_OFS, 32'h0000_0057, 32'h0000_007F, 1'b0);
        $display("Test internal run done");
        secondary_osc_enable <= 1'b1;
        core.pulse(1'b0);
        repeat (3) @(posedge clk);
        #1 `CHK({cpu_clk_en, periph_clk_en}, 2'b00)
        `CHK({lf_osc_on, secondary_osc_on, hf_osc_on}, 3'b110)
        rd(`OSC_CTRL_OFS, 32'h0000_0053, 32'h0000_007F, 1'b0);
        rd(`OSC_CTRL2_OFS, 32'h0000_0000, 32'h0000_0041, 1'b0);
        core.pulse(1'b1);
        wait_cpu(2000);
        `CHK({periph_clk_en, clk_source}, {1'b1, SRC_INT})
        rd(`OSC_CTRL_OFS, 32'h0000_0053, 32'h0000_00F3, 1'b0);
        $display("Test sleep done");
        repeat (20) @(posedge clk);
        wr(`OSC_CTRL_OFS, 32'h0000_00D3);
        core.pulse(1'b0);
        repeat (3) @(posedge clk);
        #1 `CHK({cpu_clk_en, periph_clk_en}, 2'b01)
        rd(`OSC_CTRL_OFS, 32'h0000_00D7, 32'h0000_00FF, 1'b0);
        core.pulse(1'b1);
        repeat (3) @(posedge clk);
        #1 `CHK({cpu_clk_en, periph_clk_en}, 2'b11)
        $display("Test idle done");
        do_reset(1'b1);
        wait_src(SRC_INT, 20);
        wait_cpu(40);
        rd(`OSC_CTRL_OFS, 32'h0000_0000, 32'h0000_00F3, 1'b0);
        $display("Test two-speed start done");
        {pll_enable, watchdog_enable, clock_monitor_enable} <= 3'b001;
        do_reset(1'b0);
        wait_src(SRC_INT, 20);
        wait_src(SRC_PRI, 1100);
        `CHK(n < 1044, 1'b1)
        $display("Test monitor start done");
        report_and_stop();
    end
endmodule
`default_nettype wire
